// ==== prs_pkg.sv ====
// Package for the peripheral register synchronizer: register map, field
// positions, reset values, sync timing and the bus request carrier.
// Assumes a single bus clock of 200 MHz; the core clock is sampled by it.
package prs_pkg;

  // Register byte offsets
  localparam logic [7:0] PRS_OFF_CTRL     = 8'h00;
  localparam logic [7:0] PRS_OFF_STATUS   = 8'h04;
  localparam logic [7:0] PRS_OFF_DATA     = 8'h08;
  localparam logic [7:0] PRS_OFF_COUNT    = 8'h0C;
  localparam logic [7:0] PRS_OFF_SCRATCH  = 8'h10;
  localparam logic [7:0] PRS_OFF_INTFLAG  = 8'h14;
  localparam logic [7:0] PRS_OFF_INTMASK  = 8'h18;
  localparam logic [7:0] PRS_OFF_BUSY_MAP = 8'h1C;

  // Field positions
  localparam int PRS_CTRL_RESET_BIT   = 0;
  localparam int PRS_CTRL_ENABLE_BIT  = 1;
  localparam int PRS_STATUS_PEND_BIT  = 7;
  localparam int PRS_INT_READY_BIT    = 0;
  localparam int PRS_FLAG_W           = 1;
  localparam int PRS_CORE_W           = 16;

  // Reset values
  localparam logic [31:0]           PRS_RST_SCRATCH = 32'h0000_0000;
  localparam logic [PRS_CORE_W-1:0] PRS_RST_CORE    = 16'h0000;
  localparam logic [PRS_FLAG_W-1:0] PRS_RST_FLAGS   = 1'h0;

  // Timing: core clock edges a synchronized access waits in the core domain
  localparam int         PRS_CORE_PERIOD_NS = 80;
  localparam int         PRS_BUS_PERIOD_NS  = 5;
  localparam int         PRS_CORE_WAIT_EDGES = 6;
  localparam logic [2:0] PRS_CORE_WAIT_LAST = 3'(PRS_CORE_WAIT_EDGES - 3);

  // Operations that cross into the core domain; one bit each in the busy map
  typedef enum logic [1:0] {
    PRS_OP_RESET,
    PRS_OP_WR_CTRL,
    PRS_OP_WR_DATA,
    PRS_OP_RD_COUNT
  } prs_op_t;

  // One bus access as seen by the slave
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } prs_req_t;

endpackage : prs_pkg

// ==== prs_sync.sv ====
// Peripheral register synchronizer: bus-side register file on clk plus an
// emulated core domain stepped by sampled edges of the core clock pin.
// Assumes a register master that waits on bus_stall before a new access.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module prs_sync (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        peripheral_core_clock,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  output logic             bus_rvalid,
  output logic             bus_stall,
  output logic             irq,
  output logic             core_enable
);

  // Decode which core operation an access needs, if any
  function automatic logic needs_sync(input prs_pkg::prs_req_t r);
    needs_sync = (r.wr && (r.addr == prs_pkg::PRS_OFF_CTRL || r.addr == prs_pkg::PRS_OFF_DATA))
              || (r.rd && r.addr == prs_pkg::PRS_OFF_COUNT);
  endfunction : needs_sync

  function automatic prs_pkg::prs_op_t op_of(input prs_pkg::prs_req_t r);
    if (r.addr == prs_pkg::PRS_OFF_COUNT) begin
      op_of = prs_pkg::PRS_OP_RD_COUNT;
    end else if (r.addr == prs_pkg::PRS_OFF_DATA) begin
      op_of = prs_pkg::PRS_OP_WR_DATA;
    end else if (r.wdata[prs_pkg::PRS_CTRL_RESET_BIT]) begin
      op_of = prs_pkg::PRS_OP_RESET;
    end else begin
      op_of = prs_pkg::PRS_OP_WR_CTRL;
    end
  endfunction : op_of

  logic                rst_s1_q;
  logic                rst_n;
  logic                ck_s1_q;
  logic                ck_s2_q;
  logic                ck_s3_q;
  logic                core_edge;
  prs_pkg::prs_req_t   in_req;
  prs_pkg::prs_req_t   hold_req_q;
  prs_pkg::prs_req_t   eff;
  logic                hold_q;
  logic                eff_valid;
  logic                eff_sync;
  logic                blocked;
  logic                exec;
  logic                start;
  logic                done;
  logic                busy_q;
  prs_pkg::prs_op_t    op_q;
  logic [31:0]         payload_q;
  logic                req_tgl_q;
  logic                ack_s1_q;
  logic                ack_s2_q;
  logic                soft_reset_q;
  logic                enable_sh_q;
  logic [prs_pkg::PRS_CORE_W-1:0] data_sh_q;
  logic [31:0]         scratch_q;
  logic [prs_pkg::PRS_FLAG_W-1:0] flag_q;
  logic [prs_pkg::PRS_FLAG_W-1:0] mask_q;
  logic [prs_pkg::PRS_FLAG_W-1:0] flag_clr;
  logic [prs_pkg::PRS_FLAG_W-1:0] flag_set;
  logic [3:0]          busy_map;
  logic [31:0]         rd_mux;
  logic                core_s1_q;
  logic                core_s2_q;
  logic                core_ack_q;
  logic [2:0]          core_cnt_q;
  logic                core_fire;
  logic [prs_pkg::PRS_CORE_W-1:0] core_data_q;
  logic [prs_pkg::PRS_CORE_W-1:0] core_count_q;
  logic [prs_pkg::PRS_CORE_W-1:0] core_snap_q;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // core clock sampling
  // Only the second and third stages feed the edge detector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
    end else begin
      ck_s1_q <= peripheral_core_clock;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
    end
  end

  assign core_edge = ck_s2_q & ~ck_s3_q;

  // Incoming access, or the one parked by a stall
  assign in_req    = '{wr: bus_wr, rd: bus_rd, addr: bus_addr, wdata: bus_wdata};
  assign eff       = hold_q ? hold_req_q : in_req;
  assign eff_valid = hold_q | bus_wr | bus_rd;
  assign eff_sync  = needs_sync(eff);
  // a busy sync blocks synced accesses, and during soft reset all writes too
  assign blocked   = eff_valid && busy_q && (eff_sync || (soft_reset_q && eff.wr));
  assign exec      = eff_valid && !blocked;
  assign start     = exec && eff_sync;
  assign done      = busy_q && (ack_s2_q == req_tgl_q);

  // Park a blocked access; newcomers during a stall are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q     <= 1'b0;
      hold_req_q <= '0;
      bus_stall  <= 1'b0;
    end else begin
      hold_q     <= blocked;
      hold_req_q <= eff;
      bus_stall  <= blocked;
    end
  end

  // always taken while the core clock runs below half the bus clock rate, since its edges are sampled on clk
  // Op and payload stay stable while busy, so the core may read them directly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q    <= 1'b0;
      op_q      <= prs_pkg::PRS_OP_WR_CTRL;
      payload_q <= '0;
      req_tgl_q <= 1'b0;
    end else if (start) begin
      busy_q    <= 1'b1;
      op_q      <= op_of(eff);
      payload_q <= eff.wdata;
      req_tgl_q <= ~req_tgl_q;
    end else if (done) begin
      busy_q    <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= core_ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_q <= 1'b0;
    end else if (done && op_q == prs_pkg::PRS_OP_RESET) begin
      soft_reset_q <= 1'b0;
    end else if (start && op_of(eff) == prs_pkg::PRS_OP_RESET) begin
      soft_reset_q <= 1'b1;
    end
  end

  // Shadows of core registers read back the written value immediately
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_sh_q <= 1'b0;
      data_sh_q   <= prs_pkg::PRS_RST_CORE;
    end else if (done && op_q == prs_pkg::PRS_OP_RESET) begin
      enable_sh_q <= 1'b0;
      data_sh_q   <= prs_pkg::PRS_RST_CORE;
    end else if (start && eff.addr == prs_pkg::PRS_OFF_CTRL) begin
      enable_sh_q <= eff.wdata[prs_pkg::PRS_CTRL_ENABLE_BIT];
    end else if (start && eff.addr == prs_pkg::PRS_OFF_DATA) begin
      data_sh_q   <= eff.wdata[prs_pkg::PRS_CORE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scratch_q <= prs_pkg::PRS_RST_SCRATCH;
      mask_q    <= prs_pkg::PRS_RST_FLAGS;
    end else if (done && op_q == prs_pkg::PRS_OP_RESET) begin
      scratch_q <= prs_pkg::PRS_RST_SCRATCH;
      mask_q    <= prs_pkg::PRS_RST_FLAGS;
    end else if (exec && eff.wr && eff.addr == prs_pkg::PRS_OFF_SCRATCH) begin
      scratch_q <= eff.wdata;
    end else if (exec && eff.wr && eff.addr == prs_pkg::PRS_OFF_INTMASK) begin
      mask_q    <= eff.wdata[prs_pkg::PRS_FLAG_W-1:0];
    end
  end

  assign flag_set = (done && op_q != prs_pkg::PRS_OP_RESET) ? 1'b1 : 1'b0;
  assign flag_clr = (exec && eff.wr && eff.addr == prs_pkg::PRS_OFF_INTFLAG)
                  ? eff.wdata[prs_pkg::PRS_FLAG_W-1:0] : '0;

  // Sticky flags: a set in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= prs_pkg::PRS_RST_FLAGS;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  // Level interrupt from any unmasked flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((flag_q & ~flag_clr) | flag_set) & mask_q);
    end
  end

  always_comb begin
    busy_map = 4'h0;
    if (busy_q) begin
      busy_map[op_q] = 1'b1;
    end
  end

  // Read mux for accesses answered without synchronization
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (eff.addr)
      prs_pkg::PRS_OFF_CTRL: begin
        rd_mux[prs_pkg::PRS_CTRL_RESET_BIT]  = soft_reset_q;
        rd_mux[prs_pkg::PRS_CTRL_ENABLE_BIT] = enable_sh_q;
      end
      // pending flag is the busy state
      prs_pkg::PRS_OFF_STATUS:   rd_mux[prs_pkg::PRS_STATUS_PEND_BIT] = busy_q;
      prs_pkg::PRS_OFF_DATA:     rd_mux[prs_pkg::PRS_CORE_W-1:0] = data_sh_q;
      prs_pkg::PRS_OFF_SCRATCH:  rd_mux = scratch_q;
      prs_pkg::PRS_OFF_INTFLAG:  rd_mux[prs_pkg::PRS_FLAG_W-1:0] = flag_q;
      prs_pkg::PRS_OFF_INTMASK:  rd_mux[prs_pkg::PRS_FLAG_W-1:0] = mask_q;
      prs_pkg::PRS_OFF_BUSY_MAP: rd_mux[3:0] = busy_map;
      default:                   rd_mux = 32'h0000_0000;
    endcase
  end

  // synced counter read answered on completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata  <= 32'h0000_0000;
      bus_rvalid <= 1'b0;
    end else if (done && op_q == prs_pkg::PRS_OP_RD_COUNT) begin
      bus_rdata  <= {16'h0000, core_snap_q};
      bus_rvalid <= 1'b1;
    end else if (exec && eff.rd && !eff_sync) begin
      bus_rdata  <= rd_mux;
      bus_rvalid <= 1'b1;
    end else begin
      bus_rvalid <= 1'b0;
    end
  end

  // core-side request sync
  // Stepped only on core clock edges, so it sees the core's own timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_s1_q <= 1'b0;
      core_s2_q <= 1'b0;
    end else if (core_edge) begin
      core_s1_q <= req_tgl_q;
      core_s2_q <= core_s1_q;
    end
  end

  // core edge count
  // Two sync edges plus this wait give six core edges in all
  assign core_fire = core_edge && (core_s2_q != core_ack_q) && (core_cnt_q == prs_pkg::PRS_CORE_WAIT_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_cnt_q <= 3'h0;
      core_ack_q <= 1'b0;
    end else if (core_fire) begin
      core_cnt_q <= 3'h0;
      core_ack_q <= ~core_ack_q;
    end else if (core_edge && core_s2_q != core_ack_q) begin
      core_cnt_q <= core_cnt_q + 3'h1;
    end
  end

  // core registers take effect here
  // Soft reset clears the whole core, then the ack reports it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_enable  <= 1'b0;
      core_data_q  <= prs_pkg::PRS_RST_CORE;
      core_count_q <= prs_pkg::PRS_RST_CORE;
      core_snap_q  <= prs_pkg::PRS_RST_CORE;
    end else if (core_fire) begin
      case (op_q)
        prs_pkg::PRS_OP_RESET: begin
          core_enable  <= 1'b0;
          core_data_q  <= prs_pkg::PRS_RST_CORE;
          core_count_q <= prs_pkg::PRS_RST_CORE;
          core_snap_q  <= prs_pkg::PRS_RST_CORE;
        end
        prs_pkg::PRS_OP_WR_CTRL: begin
          core_enable  <= payload_q[prs_pkg::PRS_CTRL_ENABLE_BIT];
        end
        prs_pkg::PRS_OP_WR_DATA: begin
          core_data_q  <= payload_q[prs_pkg::PRS_CORE_W-1:0];
          core_count_q <= payload_q[prs_pkg::PRS_CORE_W-1:0];
        end
        prs_pkg::PRS_OP_RD_COUNT: begin
          core_snap_q  <= core_count_q;
        end
        default: begin
          core_snap_q  <= core_snap_q;
        end
      endcase
    end else if (core_edge && core_enable) begin
      // Core counter, counts only while core_enable is set; the read-synchronized register
      core_count_q <= core_count_q + 16'h0001;
    end
  end

endmodule : prs_sync

`default_nettype wire

// ==== prs_sync_assertions.sv ====
// Checker for prs_sync: bus answer timing, read-back and core enable delay.
// Assumes a master that waits out stalls and never overlaps accesses.
`timescale 1ns/1ps
`default_nettype none

module prs_sync_assertions (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        peripheral_core_clock,
  input wire logic [7:0]  bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic        bus_rvalid,
  input wire logic        bus_stall,
  input wire logic        irq,
  input wire logic        core_enable
);
  logic [7:0] cnt_q;
  logic       pend_q;
  logic       sync_acc;

  // Accesses that cross to the core; direct reads must not restart the count
  assign sync_acc = !bus_stall && ((bus_wr && (bus_addr == prs_pkg::PRS_OFF_CTRL ||
                    bus_addr == prs_pkg::PRS_OFF_DATA)) || (bus_rd && bus_addr == prs_pkg::PRS_OFF_COUNT));

  // Cycles since the last crossing access; saturates so idle time reads large
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'hFF;
    end else if (sync_acc) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'hFF) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // A counter read stays outstanding until its data return
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else if (bus_rd && !bus_stall && bus_addr == prs_pkg::PRS_OFF_COUNT) begin
      pend_q <= 1'b1;
    end else if (bus_rvalid) begin
      pend_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_scr_pair;
    bus_wr && !bus_stall && bus_addr == prs_pkg::PRS_OFF_SCRATCH
    ##1 bus_rd && !bus_stall && bus_addr == prs_pkg::PRS_OFF_SCRATCH;
  endsequence

  sequence s_mask_off;
    bus_wr && !bus_stall && bus_addr == prs_pkg::PRS_OFF_INTMASK && bus_wdata == 32'h0 ##1 !bus_stall;
  endsequence

  chk_direct_read: assert property (
    bus_rd && !bus_stall && !pend_q && bus_addr != prs_pkg::PRS_OFF_COUNT |=> bus_rvalid && !bus_stall)
    else $error("direct read not answered next cycle");
  chk_unmapped_zero: assert property (
    bus_rd && !bus_stall && !pend_q && bus_addr == 8'h20 |=> bus_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_scratch_back: assert property (
    s_scr_pair |=> bus_rdata == $past(bus_wdata, 2))
    else $error("scratch read-back differs");
  chk_rvalid_cause: assert property (
    bus_rvalid |-> $past(bus_rd) || pend_q)
    else $error("read data without a read");
  chk_count_window: assert property (
    bus_rvalid && pend_q |-> cnt_q > 8'h50 && cnt_q < 8'h70 && bus_rdata[31:16] == 16'h0)
    else $error("counter read outside delay window");
  chk_enable_late: assert property (
    $changed(core_enable) |-> cnt_q > 8'h50)
    else $error("core enable changed too early");
  chk_enable_in_time: assert property (
    bus_wr && !bus_stall && bus_addr == prs_pkg::PRS_OFF_CTRL && bus_wdata[1:0] == 2'b10 &&
    cnt_q > 8'h78 |-> ##[1:112] core_enable)
    else $error("core enable not applied in time");
  chk_mask_quiet: assert property (
    s_mask_off |=> !irq)
    else $error("irq high with mask cleared");
endmodule : prs_sync_assertions

bind prs_sync prs_sync_assertions i_chk (.clk, .rst_b, .peripheral_core_clock, .bus_addr, .bus_wdata,
  .bus_wr, .bus_rd, .bus_rdata, .bus_rvalid, .bus_stall, .irq, .core_enable);

`default_nettype wire

// ==== prs_core_clk_src.sv ====
// Far-side model: free-running core clock source for the sync block.
// Assumes the block samples the pin with its own clock.
`timescale 1ns/1ps
`default_nettype none

module prs_core_clk_src #(
  parameter real HALF_NS = 40.0
) (
  output logic clk_out
);
  // Odd start offset keeps the phase unrelated to the bus clock
  initial begin
    clk_out = 1'b0;
    #13.7;
    forever #(HALF_NS) clk_out = ~clk_out;
  end
endmodule : prs_core_clk_src

`default_nettype wire

// ==== prs_sync_tb.sv ====
// Bench for prs_sync: random and corner register traffic against a core clock.
// Assumes the checker binds itself and the clock model is compiled first.
`timescale 1ns/1ps
`default_nettype none
`define PRS_CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module prs_sync_tb;
  logic        clk;
  logic        rst_b;
  logic        peripheral_core_clock;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] bus_rdata;
  logic        bus_rvalid;
  logic        bus_stall;
  logic        irq;
  logic        core_enable;
  int          miscompares;
  int          total_checks;
  int          seed;
  int          lat;
  logic [31:0] v;
  logic [31:0] x;
  logic        st;

  prs_sync i_dut (.clk, .rst_b, .peripheral_core_clock, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .bus_rvalid, .bus_stall, .irq, .core_enable);
  prs_core_clk_src i_core (.clk_out(peripheral_core_clock));

  // Bus clock, 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] bit_of(input int b);
    return 32'h1 << b;
  endfunction : bit_of

  // One write; with wt set it waits out a parked access and reports the stall
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit wt, output logic s);
    int n;
    n = 0;
    s = 1'b0;
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    if (wt) begin
      @(posedge clk);
      s = bus_stall;
      while (bus_stall !== 1'b0 && n < 400) begin
        @(posedge clk);
        n++;
      end
      `PRS_CHK("stall_end", 1'b0, bus_stall)
      @(posedge clk);
    end
  endtask : wr

  // One read; k is the cycle count from strobe to read data
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output int k);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (bus_rvalid !== 1'b1 && k < 400);
    `PRS_CHK("rvalid", 1'b1, bus_rvalid)
    d = bus_rdata;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a, v, lat);
    `PRS_CHK(nm, e, v)
  endtask : rchk

  // Poll the busy register; polling reads are direct and never stall
  task automatic wait_sync();
    int n;
    n = 0;
    do begin
      rd(prs_pkg::PRS_OFF_BUSY_MAP, v, lat);
      n++;
    end while (v !== 32'h0 && n < 300);
    `PRS_CHK("sync_done", 32'h0, v)
  endtask : wait_sync

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Watchdog far beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    seed = 32'hcf41;
    miscompares = 0;
    total_checks = 0;
    rst_b = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(prs_pkg::PRS_OFF_STATUS, 32'h0, "status");
    rchk(prs_pkg::PRS_OFF_BUSY_MAP, 32'h0, "busy_map");
    rchk(8'h20, 32'h0, "unmapped");
    $display("test reset done");
    // Back-to-back write and read of the bus-side scratch register
    repeat (8) begin
      x = $random(seed);
      wr(prs_pkg::PRS_OFF_SCRATCH, x, 1'b0, st);
      rd(prs_pkg::PRS_OFF_SCRATCH, v, lat);
      `PRS_CHK("scratch", x, v)
      `PRS_CHK("scratch_lat", 1, lat)
    end
    $display("test scratch done");
    repeat (40) @(posedge clk);
    wr(prs_pkg::PRS_OFF_CTRL, 32'h2, 1'b0, st);
    rchk(prs_pkg::PRS_OFF_CTRL, 32'h2, "ctrl_now");
    rchk(prs_pkg::PRS_OFF_STATUS, bit_of(7), "pending");
    rchk(prs_pkg::PRS_OFF_BUSY_MAP, bit_of(1), "busy_ctrl");
    `PRS_CHK("en_early", 1'b0, core_enable)
    wait_sync();
    `PRS_CHK("en_late", 1'b1, core_enable)
    rchk(prs_pkg::PRS_OFF_INTFLAG, 32'h1, "flag_set");
    `PRS_CHK("irq_masked", 1'b0, irq)
    wr(prs_pkg::PRS_OFF_INTMASK, 32'h1, 1'b1, st);
    `PRS_CHK("irq_on", 1'b1, irq)
    wr(prs_pkg::PRS_OFF_INTFLAG, 32'h1, 1'b1, st);
    `PRS_CHK("irq_off", 1'b0, irq)
    wr(prs_pkg::PRS_OFF_INTMASK, 32'h0, 1'b1, st);
    $display("test enable done");
    // Core data write, then a read-synchronized counter read
    x = {16'h0, 16'($random(seed))};
    wr(prs_pkg::PRS_OFF_DATA, x, 1'b1, st);
    rchk(prs_pkg::PRS_OFF_BUSY_MAP, bit_of(2), "busy_data");
    wait_sync();
    rchk(prs_pkg::PRS_OFF_DATA, x, "data_shadow");
    rd(prs_pkg::PRS_OFF_COUNT, v, lat);
    `PRS_CHK("count_hi", 16'h0, v[31:16])
    `PRS_CHK("count_slow", 1'b1, lat > 81)
    `PRS_CHK("count_fast", 1'b1, lat < 113)
    // Enabled core counter advances a few core edges between load and snapshot
    `PRS_CHK("count_val", 1'b1, 16'(v[15:0] - x[15:0]) inside {[16'h0005:16'h0006]})
    $display("test count done");
    // A zero in the reset bit must leave bus-side state alone
    x = $random(seed);
    wr(prs_pkg::PRS_OFF_SCRATCH, x, 1'b1, st);
    wr(prs_pkg::PRS_OFF_CTRL, 32'h0, 1'b1, st);
    wait_sync();
    rchk(prs_pkg::PRS_OFF_SCRATCH, x, "zero_no_reset");
    wr(prs_pkg::PRS_OFF_INTFLAG, 32'h1, 1'b1, st);
    // Soft reset with a write parked behind it
    x = $random(seed);
    wr(prs_pkg::PRS_OFF_CTRL, 32'h1, 1'b0, st);
    rchk(prs_pkg::PRS_OFF_CTRL, bit_of(0), "soft_reset_request_now");
    rchk(prs_pkg::PRS_OFF_STATUS, bit_of(7), "soft_reset_request_pend");
    wr(prs_pkg::PRS_OFF_SCRATCH, x, 1'b1, st);
    `PRS_CHK("stall_wr", 1'b1, st)
    rchk(prs_pkg::PRS_OFF_CTRL, 32'h0, "soft_reset_request_done");
    rchk(prs_pkg::PRS_OFF_STATUS, 32'h0, "pend_done");
    rchk(prs_pkg::PRS_OFF_SCRATCH, x, "parked_wr");
    rchk(prs_pkg::PRS_OFF_INTFLAG, 32'h0, "no_ready");
    $display("test soft reset done");
    end_of_test();
  end
endmodule : prs_sync_tb

`default_nettype wire
